// ---- common/osg_pkg.sv ----
// Package for the output stop and pin configuration register slice
package osg_pkg;
	localparam logic [7:0] OSG_ADDR_MUX_B    = 8'h08;
	localparam logic [7:0] OSG_ADDR_STOP_LO  = 8'h09;
	localparam logic [7:0] OSG_ADDR_STOP_HI  = 8'h0a;
	localparam logic [7:0] OSG_ADDR_PCFG_A   = 8'h0b;
	localparam logic [7:0] OSG_ADDR_PCFG_B   = 8'h0c;
	localparam logic [7:0] OSG_ADDR_SSEL0    = 8'h0d;
	localparam logic [7:0] OSG_ADDR_SSEL1    = 8'h0e;
	localparam logic [7:0] OSG_ADDR_SSEL2    = 8'h0f;
	localparam logic [7:0] OSG_ADDR_SSEL3    = 8'h10;
	localparam logic [7:0] OSG_ADDR_BUSADDR  = 8'h11;
	localparam logic [7:0] OSG_ADDR_STAT_BASE = 8'h40;
	localparam logic [7:0] OSG_ADDR_PIN_STAT = 8'h41;
	localparam logic [7:0] OSG_ADDR_SYN_IE   = 8'h4b;
	localparam logic [7:0] OSG_RESET_VAL     = 8'h00;
	localparam logic [4:0] OSG_BUSADDR_DFLT  = 5'h1d;
	localparam logic [1:0] OSG_PIN_STAT_GRP  = 2'h1;
	localparam logic [1:0] OSG_MUX_INT       = 2'h0;
	localparam logic [1:0] OSG_MUX_FRAC      = 2'h1;
	localparam logic [1:0] OSG_MUX_PATH2     = 2'h3;
	localparam logic [3:0] OSG_STOP_SRC_REG  = 4'h1;
	localparam int         OSG_NUM_OUT       = 10;
	localparam int         OSG_NUM_PIN       = 4;
	localparam int         OSG_NUM_STAT      = 32;
	typedef enum logic [3:0] {
		OSG_PIN_IN      = 4'h0,
		OSG_PIN_IN_INV  = 4'h1,
		OSG_PIN_OUT_LO  = 4'h2,
		OSG_PIN_OUT_HI  = 4'h3,
		OSG_PIN_STAT    = 4'h4,
		OSG_PIN_STAT_INV = 4'h5,
		OSG_PIN_STAT_OD0 = 4'h6,
		OSG_PIN_STAT_OD1 = 4'h7
	} osg_pin_mode_t;
endpackage : osg_pkg

// ---- design/osg_clk_mux.sv ----
// Output group clock source multiplexer
`timescale 1ns/100ps
module osg_clk_mux
	import osg_pkg::*;
(
	input  wire logic [1:0] i_sel,       // Group source select
	input  wire logic       i_clk_int,   // Integer divider clock
	input  wire logic       i_clk_frac,  // Fractional or bypass clock
	input  wire logic       i_clk_path2, // Secondary path clock
	output logic            o_clk        // Selected clock, low for unused code
);
	always_comb
	begin
		unique case (i_sel)
			OSG_MUX_INT:   o_clk = i_clk_int;
			OSG_MUX_FRAC:  o_clk = i_clk_frac;
			OSG_MUX_PATH2: o_clk = i_clk_path2;
			default:       o_clk = 1'b0;
		endcase
	end
endmodule : osg_clk_mux

// ---- design/osg_pin_ctrl.sv ----
// One general-purpose pin driver
`timescale 1ns/100ps
module osg_pin_ctrl
	import osg_pkg::*;
(
	input  wire logic [3:0] i_mode,      // Pin configuration field
	input  wire logic       i_status,    // Followed status bit
	input  wire logic       i_pin_in,    // Pin level
	output logic            o_pin_out,   // Pin output value
	output logic            o_pin_oe_n,  // Low while driving
	output logic            o_in_level   // Input after optional inversion
);
	always_comb
	begin
		o_pin_out  = 1'b0;
		o_pin_oe_n = 1'b1;
		o_in_level = i_pin_in;
		case (i_mode)
			OSG_PIN_IN_INV: o_in_level = ~i_pin_in;
			OSG_PIN_OUT_LO: o_pin_oe_n = 1'b0;
			OSG_PIN_OUT_HI:
			begin
				o_pin_out  = 1'b1;
				o_pin_oe_n = 1'b0;
			end
			OSG_PIN_STAT:
			begin
				o_pin_out  = i_status;
				o_pin_oe_n = 1'b0;
			end
			OSG_PIN_STAT_INV:
			begin
				o_pin_out  = ~i_status;
				o_pin_oe_n = 1'b0;
			end
			OSG_PIN_STAT_OD0: o_pin_oe_n = i_status;
			OSG_PIN_STAT_OD1: o_pin_oe_n = ~i_status;
			default: o_pin_oe_n = 1'b1;
		endcase
	end
endmodule : osg_pin_ctrl

// ---- design/osg_regs.sv ----
// Output stop, pin configuration and bus address register slice
`timescale 1ns/100ps
module osg_regs
	import osg_pkg::*;
(
	input  wire logic        i_mclk,          // Register clock, 200 MHz
	input  wire logic        i_reset,         // Reset pin event, sync active high
	input  wire logic        i_reg_hard_rst,  // Register hard reset
	input  wire logic        i_reg_soft_rst,  // Register soft reset
	input  wire logic        i_iface_sel_hi,  // Interface select pin high
	input  wire logic        i_iface_sel_lo,  // Interface select pin low
	input  wire logic        i_wr_en,         // Register write strobe
	input  wire logic [7:0]  i_addr,          // Register address
	input  wire logic [7:0]  i_wdata,         // Write data
	output logic      [7:0]  o_rdata,         // Read data
	input  wire logic        i_global_halt,   // Global output halt bit
	input  wire logic [39:0] i_stop_src,      // Stop source fields, 4 per output
	input  wire logic [255:0] i_status,       // Status space 40h..5Fh
	input  wire logic [255:0] i_status_impl,  // Implemented status bit map
	input  wire logic        i_clk_int,       // Integer divider clock
	input  wire logic        i_clk_frac,      // Fractional or bypass clock
	input  wire logic        i_clk_path2,     // Secondary path clock
	output logic             o_clk_out8,      // Clock for output eight
	output logic             o_clk_out67,     // Clock for outputs six, seven
	output logic [9:0]       o_stop_req,      // Per-output stop requests
	input  wire logic [3:0]  i_pin,           // Pin levels
	output logic      [3:0]  o_pin,           // Pin output values
	output logic      [3:0]  o_pin_oe_n,      // Pin enables, low drives
	output logic      [3:0]  o_pin_in_level,  // Pin inputs after inversion
	output logic      [6:0]  o_bus_address    // Two-wire bus address
);
	logic [7:0] mux_b_reg;
	logic [7:0] stop_lo_reg;
	logic [7:0] stop_hi_reg;
	logic [7:0] pcfg_a_reg;
	logic [7:0] pcfg_b_reg;
	logic [7:0] ssel_reg [OSG_NUM_PIN];
	logic [6:0] bus_addr_reg;
	logic       reg_rst;
	logic [9:0] stop_bits;
	logic [3:0] pin_status;
	logic [3:0] pin_mode [OSG_NUM_PIN];
	logic [3:0] drive_mode [OSG_NUM_PIN];
	logic [3:0] follow_ok;

	assign reg_rst = i_reset | i_reg_hard_rst | i_reg_soft_rst;

	// Status space bit index of a select value
	function automatic logic [7:0] follow_index(input logic [7:0] sel);
		return {sel[7:3], sel[2:0]};
	endfunction : follow_index

	// Selected location exists and is not excluded
	function automatic logic follow_valid(input logic [7:0] sel, input logic [255:0] impl);
		logic [7:0] addr;
		addr = OSG_ADDR_STAT_BASE + {3'h0, sel[7:3]};
		if (addr == OSG_ADDR_PIN_STAT || addr == OSG_ADDR_SYN_IE)
			return 1'b0;
		return impl[follow_index(sel)];
	endfunction : follow_valid

	// Followed value, low when the location is not valid
	function automatic logic follow_bit(input logic [7:0] sel, input logic [255:0] st,
		input logic [255:0] impl);
		return follow_valid(sel, impl) && st[follow_index(sel)];
	endfunction : follow_bit

	//----------------------------------------
	// Control registers
	//----------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (reg_rst)
		begin
			mux_b_reg   <= OSG_RESET_VAL;
			stop_lo_reg <= OSG_RESET_VAL;
			stop_hi_reg <= OSG_RESET_VAL;
			pcfg_a_reg  <= OSG_RESET_VAL;
			pcfg_b_reg  <= OSG_RESET_VAL;
		end
		else if (i_wr_en)
		begin
			unique case (i_addr)
				OSG_ADDR_MUX_B:   mux_b_reg   <= {2'h0, i_wdata[5:0]};
				OSG_ADDR_STOP_LO: stop_lo_reg <= i_wdata;
				OSG_ADDR_STOP_HI: stop_hi_reg <= {6'h00, i_wdata[1:0]};
				OSG_ADDR_PCFG_A:  pcfg_a_reg  <= i_wdata;
				OSG_ADDR_PCFG_B:  pcfg_b_reg  <= i_wdata;
				default:          ;
			endcase
		end
	end

	genvar gp;
	generate
		for (gp = 0; gp < OSG_NUM_PIN; gp++)
		begin : g_ssel
			always_ff @(posedge i_mclk)
			begin
				if (reg_rst)
					ssel_reg[gp] <= OSG_RESET_VAL;
				else if (i_wr_en && i_addr == OSG_ADDR_SSEL0 + 8'(gp))
					ssel_reg[gp] <= i_wdata;
			end
		end
	endgenerate

	//----------------------------------------
	// Bus address, reset pin only
	//----------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			bus_addr_reg <= {OSG_BUSADDR_DFLT, i_iface_sel_hi, i_iface_sel_lo};
		else if (i_wr_en && i_addr == OSG_ADDR_BUSADDR)
			bus_addr_reg <= i_wdata[6:0];
	end
	assign o_bus_address = bus_addr_reg;

	//----------------------------------------
	// Clock groups and stop requests
	//----------------------------------------
	osg_clk_mux u_mux_e
	(
		.i_sel       (mux_b_reg[3:2]),
		.i_clk_int   (i_clk_int),
		.i_clk_frac  (i_clk_frac),
		.i_clk_path2 (i_clk_path2),
		.o_clk       (o_clk_out8)
	);
	osg_clk_mux u_mux_d
	(
		.i_sel       (mux_b_reg[1:0]),
		.i_clk_int   (i_clk_int),
		.i_clk_frac  (i_clk_frac),
		.i_clk_path2 (i_clk_path2),
		.o_clk       (o_clk_out67)
	);

	assign stop_bits = {stop_hi_reg[1:0], stop_lo_reg};
	genvar go;
	generate
		for (go = 0; go < OSG_NUM_OUT; go++)
		begin : g_stop
			always_ff @(posedge i_mclk)
			begin
				if (i_reset)
					o_stop_req[go] <= 1'b0;
				else
					o_stop_req[go] <= (i_stop_src[go*4 +: 4] == OSG_STOP_SRC_REG)
						&& (stop_bits[go] || i_global_halt);
			end
		end
	endgenerate

	//----------------------------------------
	// Pins
	//----------------------------------------
	assign pin_mode[0] = pcfg_a_reg[3:0];
	assign pin_mode[1] = pcfg_a_reg[7:4];
	assign pin_mode[2] = pcfg_b_reg[3:0];
	assign pin_mode[3] = pcfg_b_reg[7:4];

	// Status modes with an invalid select drive the pin low
	generate
		for (gp = 0; gp < OSG_NUM_PIN; gp++)
		begin : g_follow
			assign follow_ok[gp]  = follow_valid(ssel_reg[gp], i_status_impl);
			assign drive_mode[gp] = (pin_mode[gp][3:2] == OSG_PIN_STAT_GRP && !follow_ok[gp])
				? OSG_PIN_OUT_LO : pin_mode[gp];
		end
	endgenerate

	generate
		for (gp = 0; gp < OSG_NUM_PIN; gp++)
		begin : g_pin
			osg_pin_ctrl u_pin
			(
				.i_mode     (drive_mode[gp]),
				.i_status   (follow_bit(ssel_reg[gp], i_status, i_status_impl)),
				.i_pin_in   (i_pin[gp]),
				.o_pin_out  (o_pin[gp]),
				.o_pin_oe_n (o_pin_oe_n[gp]),
				.o_in_level (o_pin_in_level[gp])
			);
		end
	endgenerate

	assign pin_status = i_pin;

	//----------------------------------------
	// Read port
	//----------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			o_rdata <= OSG_RESET_VAL;
		else
		begin
			unique case (i_addr)
				OSG_ADDR_MUX_B:    o_rdata <= mux_b_reg;
				OSG_ADDR_STOP_LO:  o_rdata <= stop_lo_reg;
				OSG_ADDR_STOP_HI:  o_rdata <= stop_hi_reg;
				OSG_ADDR_PCFG_A:   o_rdata <= pcfg_a_reg;
				OSG_ADDR_PCFG_B:   o_rdata <= pcfg_b_reg;
				OSG_ADDR_SSEL0:    o_rdata <= ssel_reg[0];
				OSG_ADDR_SSEL1:    o_rdata <= ssel_reg[1];
				OSG_ADDR_SSEL2:    o_rdata <= ssel_reg[2];
				OSG_ADDR_SSEL3:    o_rdata <= ssel_reg[3];
				OSG_ADDR_BUSADDR:  o_rdata <= {1'b0, bus_addr_reg};
				OSG_ADDR_PIN_STAT: o_rdata <= {4'h0, pin_status};
				default:           o_rdata <= OSG_RESET_VAL;
			endcase
		end
	end

	//----------------------------------------
	// Stop and clock assertions
	//----------------------------------------
	a_stop_or: assert property (@(posedge i_mclk) disable iff (i_reset)
		(i_stop_src[3:0] == OSG_STOP_SRC_REG && i_global_halt) |=> o_stop_req[0])
		else $error("global halt did not stop output one");
	a_stop_src: assert property (@(posedge i_mclk) disable iff (i_reset)
		(i_stop_src[7:4] != OSG_STOP_SRC_REG) |=> !o_stop_req[1])
		else $error("stop raised with other source");
	a_stop_lo_map: assert property (@(posedge i_mclk) disable iff (i_reset)
		(i_stop_src[31:28] == OSG_STOP_SRC_REG && stop_lo_reg[7]) |=> o_stop_req[7])
		else $error("stop bit did not stop output eight");
	a_stop_hi: assert property (@(posedge i_mclk) disable iff (i_reset)
		(i_stop_src[39:36] == OSG_STOP_SRC_REG && stop_hi_reg[1]) |=> o_stop_req[9])
		else $error("high stop bit did not stop output ten");
	a_group_e: assert property (@(posedge i_mclk) disable iff (i_reset)
		mux_b_reg[3:2] == OSG_MUX_PATH2 |-> o_clk_out8 == i_clk_path2)
		else $error("output eight not on secondary path");
	a_group_e_int: assert property (@(posedge i_mclk) disable iff (i_reset)
		mux_b_reg[3:2] == OSG_MUX_INT |-> o_clk_out8 == i_clk_int)
		else $error("output eight not on integer divider");
	a_group_d: assert property (@(posedge i_mclk) disable iff (i_reset)
		mux_b_reg[1:0] == OSG_MUX_FRAC |-> o_clk_out67 == i_clk_frac)
		else $error("outputs six and seven not on fractional clock");

	//----------------------------------------
	// Register assertions
	//----------------------------------------
	a_addr_keep: assert property (@(posedge i_mclk) disable iff (i_reset)
		(!(i_wr_en && i_addr == OSG_ADDR_BUSADDR)) |=> $stable(bus_addr_reg))
		else $error("bus address changed without write");
	a_addr_load: assert property (@(posedge i_mclk)
		i_reset |=> bus_addr_reg[6:2] == OSG_BUSADDR_DFLT)
		else $error("bus address default not loaded");
	a_soft_clear: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_reg_soft_rst |=> stop_lo_reg == OSG_RESET_VAL && pcfg_a_reg == OSG_RESET_VAL)
		else $error("soft reset left control set");
	a_hard_keep: assert property (@(posedge i_mclk) disable iff (i_reset)
		(i_reg_hard_rst || i_reg_soft_rst) && !i_wr_en |=> $stable(bus_addr_reg))
		else $error("register reset changed bus address");
	a_ssel_write: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_wr_en && i_addr == OSG_ADDR_SSEL3 && !reg_rst |=> ssel_reg[3] == $past(i_wdata))
		else $error("status select write lost");
	a_unmapped_zero: assert property (@(posedge i_mclk) disable iff (i_reset)
		(i_addr > OSG_ADDR_BUSADDR && i_addr < OSG_ADDR_STAT_BASE) |=> o_rdata == OSG_RESET_VAL)
		else $error("unmapped address read nonzero");
	a_hi_unused: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_addr == OSG_ADDR_STOP_HI |=> o_rdata[7:2] == 6'h00)
		else $error("unused stop bits read nonzero");

	//----------------------------------------
	// Pin and read port assertions
	//----------------------------------------
	a_pin_drive_hi: assert property (@(posedge i_mclk) disable iff (i_reset)
		pin_mode[0] == OSG_PIN_OUT_HI |-> o_pin[0] && !o_pin_oe_n[0])
		else $error("pin zero not driving high");
	a_pin_input: assert property (@(posedge i_mclk) disable iff (i_reset)
		pin_mode[1] == OSG_PIN_IN |-> o_pin_oe_n[1])
		else $error("input pin is driving");
	a_pin_read: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_addr == OSG_ADDR_PIN_STAT |=> o_rdata[3:0] == $past(i_pin))
		else $error("pin status not raw level");
	a_bit7_zero: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_addr == OSG_ADDR_BUSADDR |=> !o_rdata[7])
		else $error("bus address bit 7 set");
	a_drive_lo: assert property (@(posedge i_mclk) disable iff (i_reset)
		pin_mode[3] == OSG_PIN_OUT_LO |-> !o_pin[3] && !o_pin_oe_n[3])
		else $error("pin three not driving low");
	a_od_drive: assert property (@(posedge i_mclk) disable iff (i_reset)
		pin_mode[1] == OSG_PIN_STAT_OD0 |-> !o_pin[1])
		else $error("open-drain pin drove high");
	a_unimpl_low: assert property (@(posedge i_mclk) disable iff (i_reset)
		pin_mode[2][3:2] == OSG_PIN_STAT_GRP && !i_status_impl[ssel_reg[2]] |-> !o_pin[2] && !o_pin_oe_n[2])
		else $error("unimplemented status select not driving low");
	a_pinstat_excl: assert property (@(posedge i_mclk) disable iff (i_reset)
		pin_mode[3][3:2] == OSG_PIN_STAT_GRP
		&& OSG_ADDR_STAT_BASE + {3'h0, ssel_reg[3][7:3]} == OSG_ADDR_PIN_STAT |-> !o_pin[3] && !o_pin_oe_n[3])
		else $error("pin status register was followed");

	//----------------------------------------
	// Cover points
	//----------------------------------------
	c_halt: cover property (@(posedge i_mclk) o_stop_req[0]);
	c_pin_stat: cover property (@(posedge i_mclk) pin_mode[2] == OSG_PIN_STAT && o_pin[2]);
	c_addr_wr: cover property (@(posedge i_mclk) i_wr_en && i_addr == OSG_ADDR_BUSADDR);
	c_unimpl: cover property (@(posedge i_mclk) pin_mode[1][3:2] == OSG_PIN_STAT_GRP && !follow_ok[1]);
	c_od_float: cover property (@(posedge i_mclk) pin_mode[0] == OSG_PIN_STAT_OD1 && o_pin_oe_n[0]);
endmodule : osg_regs

// ---- verif/osg_host_model.sv ----
// Host-side register access model for the register slice
`timescale 1ns/100ps
module osg_host_model
(
	input  wire logic       i_mclk,  // Register clock
	input  wire logic [7:0] i_rdata, // Read data from slice
	output logic            o_wr_en, // Write strobe
	output logic      [7:0] o_addr,  // Register address
	output logic      [7:0] o_wdata  // Write data
);
	initial
	begin
		o_wr_en = 1'b0;
		o_addr  = 8'h00;
		o_wdata = 8'h00;
	end

	// Strobe held over exactly one taking edge
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_mclk);
		o_wr_en = 1'b1;
		o_addr  = a;
		o_wdata = d;
		@(negedge i_mclk);
		o_wr_en = 1'b0;
		o_wdata = ~d;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_mclk);
		o_addr = a;
		@(negedge i_mclk);
		d = i_rdata;
	endtask : read_reg
endmodule : osg_host_model

// ---- verif/osg_regs_tb_top.sv ----
// Self-checking bench for the register slice
`timescale 1ns/100ps
module osg_regs_tb_top;
	import osg_pkg::*;
	localparam logic [4:0] BUS_DFLT = 5'b11101;
	logic         mclk;
	logic         reset;
	logic         hard_rst;
	logic         soft_rst;
	logic [1:0]   if_sel;
	logic         wr_en;
	logic [7:0]   addr;
	logic [7:0]   wdata;
	logic [7:0]   rdata;
	logic         halt;
	logic [39:0]  stop_src;
	logic [255:0] status;
	logic [255:0] impl;
	logic [2:0]   clk_lv;
	logic         clk8;
	logic         clk67;
	logic [9:0]   stop_req;
	logic [3:0]   ext_pin;
	logic [3:0]   pin_wire;
	logic [3:0]   pin_out;
	logic [3:0]   pin_oe_n;
	logic [3:0]   in_level;
	logic [6:0]   bus_addr;
	logic [9:0]   e_stop;
	logic [7:0]   ssel;
	logic         s_bit;
	logic         s_ok;
	logic         eo;
	logic         ev;
	logic [7:0]   mdl [0:255];
	int           fail_count;
	int           samples_checked;
	int           seed;

	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	assign pin_wire = (~pin_oe_n & pin_out) | (pin_oe_n & ext_pin);

	osg_regs osg_regs_inst (
		.i_mclk(mclk), .i_reset(reset), .i_reg_hard_rst(hard_rst), .i_reg_soft_rst(soft_rst),
		.i_iface_sel_hi(if_sel[1]), .i_iface_sel_lo(if_sel[0]), .i_wr_en(wr_en),
		.i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_global_halt(halt),
		.i_stop_src(stop_src), .i_status(status), .i_status_impl(impl),
		.i_clk_int(clk_lv[0]), .i_clk_frac(clk_lv[1]), .i_clk_path2(clk_lv[2]),
		.o_clk_out8(clk8), .o_clk_out67(clk67), .o_stop_req(stop_req), .i_pin(pin_wire),
		.o_pin(pin_out), .o_pin_oe_n(pin_oe_n), .o_pin_in_level(in_level),
		.o_bus_address(bus_addr));
	osg_host_model osg_host_model_inst (
		.i_mclk(mclk), .i_rdata(rdata), .o_wr_en(wr_en), .o_addr(addr), .o_wdata(wdata));

	function automatic logic [7:0] rmask(input logic [7:0] a);
		case (a)
			8'h08: return 8'h3f;
			8'h0a: return 8'h03;
			8'h11: return 8'h7f;
			8'h09, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10: return 8'hff;
			default: return 8'h00;
		endcase
	endfunction : rmask

	function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
		if (a == 8'h0b || a == 8'h0c)
			return d & 8'h77;
		if (a == 8'h11 && d[6:0] == 7'h00)
			return 8'h01;
		return d;
	endfunction : legal

	function automatic logic muxv(input logic [1:0] sel, input logic [2:0] lv);
		return (sel == 2'h0) ? lv[0] : (sel == 2'h1) ? lv[1] : (sel == 2'h3) ? lv[2] : 1'b0;
	endfunction : muxv

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d0);
		logic [7:0] d;
		d = legal(a, d0);
		osg_host_model_inst.write_reg(a, d);
		mdl[a] = d & rmask(a);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a);
		logic [7:0] d;
		logic [7:0] e;
		e = (a == 8'h41) ? {4'h0, pin_wire} : mdl[a];
		osg_host_model_inst.read_reg(a, d);
		check($sformatf("rdata at %0h", a), d, e);
	endtask : rd_chk

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	// Hang guard
	initial
	begin
		#200000;
		fail_count++;
		complete_run();
	end

	initial
	begin
		fail_count = 0;
		samples_checked = 0;
		seed = 32'h5b5d;
		{hard_rst, soft_rst, halt, stop_src, clk_lv, ext_pin} = '0;
		reset = 1'b1;
		if_sel = 2'b10;
		for (int i = 0; i < 8; i++)
			{status[32*i +: 32], impl[32*i +: 32]} = {$random(seed), $random(seed)};
		for (int a = 0; a < 256; a++)
			mdl[a] = 8'h00;
		mdl[8'h11] = {1'b0, BUS_DFLT, 2'b10};
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		for (int a = 7; a < 19; a++)
			rd_chk(8'(a));
		check("bus_addr", bus_addr, mdl[8'h11]);
		check("stop_req", stop_req, 10'h000);
		$display("reset values done");
		repeat (3) for (int a = 7; a < 19; a++)
		begin
			wr(8'(a), 8'($random(seed)));
			rd_chk(8'(a));
		end
		ext_pin = 4'($random(seed));
		rd_chk(8'h41);
		$display("register access done");
		for (int k = 0; k < 2; k++)
		begin
			@(negedge mclk);
			{hard_rst, soft_rst} = (k == 0) ? 2'b10 : 2'b01;
			@(negedge mclk);
			{hard_rst, soft_rst} = 2'b00;
			for (int a = 8; a < 17; a++)
				mdl[a] = 8'h00;
			for (int a = 8; a < 18; a++)
				rd_chk(8'(a));
			check("bus_addr", bus_addr, mdl[8'h11]);
		end
		$display("register resets done");
		repeat (20)
		begin
			wr(8'h09, 8'($random(seed)));
			wr(8'h0a, 8'($random(seed)));
			halt = 1'($random(seed));
			for (int n = 0; n < 10; n++)
				stop_src[4*n +: 4] = $random(seed) & 1 ? 4'h1 : 4'($random(seed));
			repeat (2) @(negedge mclk);
			for (int n = 0; n < 10; n++)
				e_stop[n] = (stop_src[4*n +: 4] == 4'h1) && ({mdl[10][1:0], mdl[9]} >> n) & 1 | halt;
			check("stop_req", stop_req, e_stop);
		end
		$display("stop requests done");
		for (int c = 0; c < 16; c++)
		begin
			wr(8'h08, 8'(c));
			clk_lv = 3'($random(seed));
			@(negedge mclk);
			check("clk_out8", clk8, muxv(2'(c >> 2), clk_lv));
			check("clk_out67", clk67, muxv(2'(c), clk_lv));
		end
		$display("clock select done");
		for (int p = 0; p < 4; p++) for (int m = 0; m < 16; m++)
		begin
			ssel = 8'($random(seed));
			if (m == 12)
				ssel[7:3] = p[0] ? 5'h01 : 5'h0b;
			wr(8'(8'h0d + p), ssel);
			wr(8'(8'h0b + p / 2), 8'((m % 8) << (4 * (p % 2))));
			ext_pin = 4'($random(seed));
			@(negedge mclk);
			s_ok = ssel[7:3] != 5'h01 && ssel[7:3] != 5'h0b && impl[ssel];
			s_bit = status[ssel];
			eo = (m % 8 < 2) || (s_ok && ((m % 8 == 6 && s_bit) || (m % 8 == 7 && !s_bit)));
			ev = (m % 8 >= 4) ? (s_ok && (m % 8 < 6) && (s_bit ^ m[0])) : m[0];
			check("pin_oe_n", pin_oe_n[p], eo);
			if (!eo)
				check("pin_out", pin_out[p], ev);
			if (m % 8 < 2)
				check("in_level", in_level[p], ext_pin[p] ^ m[0]);
			rd_chk(8'h41);
		end
		$display("pin modes done");
		complete_run();
	end
endmodule : osg_regs_tb_top
